/* File: rtl/atr_ctrl.sv */
// Trigger, sampling-time, range-check and interrupt control for the ADC.
// Assumes the analog core and timers run on CORE_CLK and give pulses.
// Function
// - Timer period match starts conversion sequence
// - Writing start bit one starts conversion
// - Sampling lasts 3, 5, 7 or 9 clocks
// - Sample time field resets to nine clocks
// - Compare channel field picks checked input
// - Only selected channel raises range interrupt
// - Separate ten-bit upper and lower limits
// - Strictly beyond limit is out of range
// - Range check only while its enable set
// - Channel zero drives over and under signals
// - Out-of-range interrupt only in advanced mode
// - Completion enable gates done interrupt, resets one
// - Range enable gates range interrupt, resets zero
// - Range request ORed into done by default
// - Split bit delivers both requests separately
// - Per-channel done masks, all reset to one
// - Two-bit trigger source, software by default
// - Extended bits reachable only in advanced mode
// - Triggers need enable; start bit shows busy
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module atr_ctrl #(
    parameter int NCH = 8    // Channels with a mask bit
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CORE_CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic TMR_MATCH,
    input wire logic TM8_UNDERFLOW,
    input wire logic EXT_TRIG,
    input wire logic CONV_DONE,
    input wire logic [2:0] CONV_CHAN,
    input wire logic [9:0] CONV_RESULT,
    input wire logic CONV_SEQ_END,
    output logic CONV_START,
    output logic [3:0] SAMPLE_CLKS,
    output logic TMR_OVER,
    output logic TMR_UNDER,
    output logic IRQ_DONE,
    output logic IRQ_RANGE
);
    import atr_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte address of a register index
    function automatic logic [31:0] addr_of(input logic [15:0] idx);
        addr_of = {14'h0000, idx, 2'h0};
    endfunction

    // Sampling clocks for a sample-time code
    function automatic logic [3:0] samp(input logic [1:0] code);
        samp = SAMPLE_BASE + {1'b0, code, 1'b0};
    endfunction

    // Out-of-range test; equality counts as inside
    function automatic logic above(input logic [9:0] r,
                                   input logic [9:0] lim);
        above = r > lim;
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic ena_q;             // converter_enable
    logic [1:0] smp_q;       // sample_time_select
    logic [2:0] cmp_q;       // compare_channel_select
    logic cmpe_q;            // range_check_enable
    logic done_en_q;         // done_irq_enable
    logic range_en_q;        // range_irq_enable
    logic split_q;           // irq_split_select
    logic [1:0] trg_q;       // trigger_source_select
    logic adv_q;             // advanced_feature_select
    logic [9:0] upr_q;       // upper_limit_value
    logic [9:0] lwr_q;       // lower_limit_value
    logic [NCH-1:0] msk_q;   // done_irq_channel_mask
    atr_state_e state_q;     // Sequence state
    atr_state_e state_d;
    logic ext_s1_q;          // External pin, first stage
    logic ext_s2_q;          // External pin, second stage

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic wr_en;             // Write takes effect this edge
    logic setup;             // Setup cycle of any transfer
    logic hit_ctl, hit_trig, hit_upr, hit_lwr, hit_msk, hit_adv;
    logic mapped;

    assign wr_en = CORE_CE & PSEL & PENABLE & PWRITE;
    assign setup = CORE_CE & PSEL & ~PENABLE;
    assign hit_ctl = PADDR == addr_of(CTL_IDX);
    assign hit_trig = PADDR == addr_of(TRIG_IDX);
    assign hit_upr = PADDR == addr_of(UPR_IDX);
    assign hit_lwr = PADDR == addr_of(LWR_IDX);
    assign hit_msk = PADDR == addr_of(MSK_IDX);
    assign hit_adv = PADDR == addr_of(ADV_IDX);
    assign mapped = hit_ctl | hit_trig | hit_upr | hit_lwr
                  | hit_msk | hit_adv;
    // Zero-wait slave; data was prepared in setup
    assign PREADY = 1'b1;

    // ------------------------------------------------------------
    // Standard control bits
    // ------------------------------------------------------------
    // Enable, sample time and trigger source
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ena_q <= 1'b0;
            smp_q <= SMP_RST;
            trg_q <= TRG_SW;
            adv_q <= 1'b0;
        end else if (CORE_CE) begin
            if (wr_en && hit_ctl) begin
                ena_q <= PWDATA[ENA_BIT];
                smp_q <= PWDATA[SMP_LSB +: 2];
            end
            if (wr_en && hit_trig) begin
                trg_q <= PWDATA[TRG_LSB +: 2];
            end
            if (wr_en && hit_adv) begin
                adv_q <= PWDATA[ADV_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Advanced-mode control bits
    // ------------------------------------------------------------
    // Writes ignored in standard mode, so a stray
    // write cannot arm hidden features
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            cmp_q <= CMP_RST;
            cmpe_q <= 1'b0;
            done_en_q <= DONE_EN_RST;
            range_en_q <= RANGE_EN_RST;
            split_q <= 1'b0;
            upr_q <= 10'h000;
            lwr_q <= 10'h000;
            msk_q <= '1;
        end else if (CORE_CE && adv_q) begin
            if (wr_en && hit_ctl) begin
                cmp_q <= PWDATA[CMP_LSB +: 3];
                cmpe_q <= PWDATA[CMPE_BIT];
                done_en_q <= PWDATA[DONE_EN_BIT];
                range_en_q <= PWDATA[RANGE_EN_BIT];
                split_q <= PWDATA[SPLIT_BIT];
            end
            if (wr_en && hit_upr) begin
                upr_q <= PWDATA[9:0];
            end
            if (wr_en && hit_lwr) begin
                lwr_q <= PWDATA[9:0];
            end
            if (wr_en && hit_msk) begin
                msk_q <= PWDATA[NCH-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Trigger selection
    // ------------------------------------------------------------
    // External pin is asynchronous: two stages first
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ext_s1_q <= 1'b1;
            ext_s2_q <= 1'b1;
        end else if (CORE_CE) begin
            ext_s1_q <= EXT_TRIG;
            ext_s2_q <= ext_s1_q;
        end
    end

    logic sw_start;          // Software start write
    logic trig;              // Selected trigger
    assign sw_start = wr_en & hit_ctl & PWDATA[START_BIT];

    // Only the selected source counts
    always_comb begin
        case (trg_q)
            TRG_SW: trig = sw_start;
            TRG_TMR: trig = TMR_MATCH;
            TRG_TM8: trig = TM8_UNDERFLOW;
            TRG_EXT: trig = ~ext_s2_q;                   // Active low
            default: trig = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Sequence state
    // ------------------------------------------------------------
    // Triggers while busy are ignored; the core
    // cannot start twice in one sequence
    always_comb begin
        state_d = state_q;
        case (state_q)
            SEQ_IDLE: begin
                if (ena_q && trig) begin
                    state_d = SEQ_BUSY;
                end
            end
            SEQ_BUSY: begin
                if (!ena_q || CONV_SEQ_END) begin
                    state_d = SEQ_IDLE;
                end
            end
            default: state_d = SEQ_IDLE;
        endcase
    end

    // State register and start pulse
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state_q <= SEQ_IDLE;
            CONV_START <= 1'b0;
        end else if (CORE_CE) begin
            state_q <= state_d;
            CONV_START <= (state_q == SEQ_IDLE)
                        && (state_d == SEQ_BUSY);
        end
    end

    // Sampling length to the core
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            SAMPLE_CLKS <= samp(SMP_RST);
        end else if (CORE_CE) begin
            SAMPLE_CLKS <= samp(smp_q);
        end
    end

    // ------------------------------------------------------------
    // Range check
    // ------------------------------------------------------------
    logic chk_on;            // Check active
    logic over;              // Result above upper limit
    logic under;             // Result below lower limit
    logic sel_hit;           // Result is from compared channel
    assign chk_on = adv_q & cmpe_q;
    assign over = above(CONV_RESULT, upr_q);
    assign under = above(lwr_q, CONV_RESULT);
    // Reserved codes never match
    assign sel_hit = CONV_DONE && (cmp_q <= CMP_LAST)
                   && (CONV_CHAN == cmp_q);

    // Channel zero levels to the timer; held to next channel-zero result while chk_on, zero while the check is off
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            TMR_OVER <= 1'b0;
            TMR_UNDER <= 1'b0;
        end else if (CORE_CE) begin
            if (!chk_on) begin
                TMR_OVER <= 1'b0;
                TMR_UNDER <= 1'b0;
            end else if (CONV_DONE && CONV_CHAN == 3'h0) begin
                TMR_OVER <= over;
                TMR_UNDER <= under;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt requests
    // ------------------------------------------------------------
    logic range_req;         // Out-of-range event
    logic done_req;          // Completion event
    // Evaluated as the result is stored
    assign range_req = chk_on & range_en_q & sel_hit
                     & (over | under);
    // Standard mode: always requested, no masks
    assign done_req = CONV_DONE
                    & (~adv_q | (done_en_q & msk_q[CONV_CHAN]));

    // One-cycle pulses toward the interrupt controller
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            IRQ_DONE <= 1'b0;
            IRQ_RANGE <= 1'b0;
        end else if (CORE_CE) begin
            IRQ_DONE <= done_req
                      | (range_req & ~split_q);
            IRQ_RANGE <= range_req & split_q;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rd;         // Selected read value
    // Hidden fields read zero in standard mode
    always_comb begin
        rd = 32'h0000_0000;
        if (hit_ctl) begin
            rd[START_BIT] = state_q == SEQ_BUSY;
            rd[ENA_BIT] = ena_q;
            rd[SMP_LSB +: 2] = smp_q;
            if (adv_q) begin
                rd[DONE_EN_BIT] = done_en_q;
                rd[RANGE_EN_BIT] = range_en_q;
                rd[SPLIT_BIT] = split_q;
                rd[CMP_LSB +: 3] = cmp_q;
                rd[CMPE_BIT] = cmpe_q;
            end
        end else if (hit_trig) begin
            rd[TRG_LSB +: 2] = trg_q;
        end else if (hit_upr && adv_q) begin
            rd[9:0] = upr_q;
        end else if (hit_lwr && adv_q) begin
            rd[9:0] = lwr_q;
        end else if (hit_msk && adv_q) begin
            rd[NCH-1:0] = msk_q;
        end else if (hit_adv) begin
            rd[ADV_BIT] = adv_q;
        end
    end

    // Captured in setup, shown in access
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (setup) begin
            PRDATA <= PWRITE ? 32'h0000_0000 : rd;
            PSLVERR <= ~mapped;                          // Unmapped
        end
    end

endmodule // atr_ctrl

/* File: rtl/atr_pkg.sv */
// Package for the converter trigger, range check and interrupt control.
// Assumes a 32-bit APB bus; register indices times four are byte addresses.
package atr_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is index times four)
    // ------------------------------------------------------------
    localparam logic [15:0] TRIG_IDX = 16'h5542; // Trigger select
    localparam logic [15:0] CTL_IDX = 16'h5544;  // adc_control_status
    localparam logic [15:0] UPR_IDX = 16'h5558;  // upper_limit_value
    localparam logic [15:0] LWR_IDX = 16'h555A;  // lower_limit_value
    localparam logic [15:0] MSK_IDX = 16'h555C;  // completion_irq_mask
    localparam logic [15:0] ADV_IDX = 16'h555E;  // Advanced select
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int START_BIT = 1;     // software_start_bit
    localparam int ENA_BIT = 2;       // converter_enable
    localparam int DONE_EN_BIT = 4;   // done_irq_enable
    localparam int RANGE_EN_BIT = 5;  // range_irq_enable
    localparam int SPLIT_BIT = 6;     // irq_split_select
    localparam int SMP_LSB = 8;       // sample_time_select
    localparam int CMP_LSB = 12;      // compare_channel_select
    localparam int CMPE_BIT = 15;     // range_check_enable
    localparam int TRG_LSB = 3;       // trigger_source_select
    localparam int ADV_BIT = 8;       // advanced_feature_select
    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [1:0] SMP_RST = 2'h3;
    localparam logic [2:0] CMP_RST = 3'h0;
    localparam logic [2:0] CMP_LAST = 3'h3;   // Highest real input
    localparam logic DONE_EN_RST = 1'b1;
    localparam logic RANGE_EN_RST = 1'b0;
    localparam logic [1:0] TRG_SW = 2'h0;
    localparam logic [1:0] TRG_TMR = 2'h1;
    localparam logic [1:0] TRG_TM8 = 2'h2;
    localparam logic [1:0] TRG_EXT = 2'h3;
    localparam logic [3:0] SAMPLE_BASE = 4'h3; // Least sampling clocks
    // Conversion sequence state
    typedef enum logic {
        SEQ_IDLE = 1'b0,
        SEQ_BUSY = 1'b1
    } atr_state_e;
endpackage

/* File: verification/atr_ctrl_assertions.sv */
// Port-level checks for the converter trigger and range control.
// Assumes one core clock, a synchronous high reset and a bind.
`timescale 1ns/1ps
module atr_ctrl_assertions
    import atr_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic TMR_MATCH,
    input wire logic TM8_UNDERFLOW,
    input wire logic EXT_TRIG,
    input wire logic CONV_DONE,
    input wire logic [2:0] CONV_CHAN,
    input wire logic CONV_START,
    input wire logic [3:0] SAMPLE_CLKS,
    input wire logic TMR_OVER,
    input wire logic TMR_UNDER,
    input wire logic IRQ_DONE,
    input wire logic IRQ_RANGE
);
    // ----
    // Helpers
    // ----
    default clocking dc @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    logic acc_w; // Write taken at this edge
    logic adv_q; // Mirror of the advanced select bit
    assign acc_w = PSEL && PENABLE && PWRITE;
    // Mirror kept so that hidden reads can be judged
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            adv_q <= 1'b0;
        end else if (acc_w && PADDR == {14'h0, ADV_IDX, 2'h0}) begin
            adv_q <= PWDATA[ADV_BIT];
        end
    end
    // ----
    // Properties
    // ----
    property p_rst_vals;
        $fell(RST) |-> SAMPLE_CLKS == 4'h9 && !CONV_START && !IRQ_DONE
            && !IRQ_RANGE && !TMR_OVER && !TMR_UNDER;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("outputs not at reset values");
    property p_sample;
        acc_w && PADDR == {14'h0, CTL_IDX, 2'h0} |-> ##2 SAMPLE_CLKS ==
            SAMPLE_BASE + {1'b0, $past(PWDATA[9:8], 2), 1'b0};
    endproperty
    a_sample: assert property (p_sample)
        else $error("sampling length wrong");
    property p_start_pulse;
        CONV_START |=> !CONV_START;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start longer than one cycle");
    property p_start_cause;
        CONV_START |-> $past(TMR_MATCH) || $past(TM8_UNDERFLOW)
            || $past(acc_w && PWDATA[START_BIT]) || !$past(EXT_TRIG, 2)
            || !$past(EXT_TRIG, 3) || !$past(EXT_TRIG, 4);
    endproperty
    a_start_cause: assert property (p_start_cause)
        else $error("start without a trigger");
    property p_done_cause;
        IRQ_DONE |-> $past(CONV_DONE);
    endproperty
    a_done_cause: assert property (p_done_cause)
        else $error("done request without a result");
    property p_range_cause;
        IRQ_RANGE |-> $past(CONV_DONE && CONV_CHAN <= CMP_LAST && adv_q);
    endproperty
    a_range_cause: assert property (p_range_cause)
        else $error("range request without cause");
    property p_flags_cause;
        $changed(TMR_OVER) || $changed(TMR_UNDER) |-> $past(RST)
            || $past(CONV_DONE && CONV_CHAN == 3'h0) || $past(acc_w, 2);
    endproperty
    a_flags_cause: assert property (p_flags_cause)
        else $error("timer flags moved without cause");
    property p_adv_hidden;
        PSEL && !PENABLE && !PWRITE && !adv_q
            && (PADDR == {14'h0, UPR_IDX, 2'h0}
            || PADDR == {14'h0, LWR_IDX, 2'h0}
            || PADDR == {14'h0, MSK_IDX, 2'h0}) |=> PRDATA == 32'h0;
    endproperty
    a_adv_hidden: assert property (p_adv_hidden)
        else $error("advanced register visible in standard mode");
endmodule // atr_ctrl_assertions

/* File: verification/atr_far_model.sv */
// Far side: timer period match and the converter core result stream.
// Assumes one core clock; the bench sets channel, result and latency.
`timescale 1ns/1ps
module atr_far_model (
    input wire logic clk,
    input wire logic fire,
    input wire logic [7:0] lat,
    input wire logic [2:0] chan,
    input wire logic [9:0] res,
    input wire logic conv_start,
    output logic tmr_match = 1'b0,
    output logic conv_done = 1'b0,
    output logic [2:0] conv_chan = 3'h0,
    output logic [9:0] conv_result = 10'h0,
    output logic conv_seq_end = 1'b0
);
    int cnt = -1; // Cycles to the result, -1 while idle
    // One result per sequence, then the end pulse
    always @(posedge clk) begin
        tmr_match <= fire; // Period match as a one-cycle pulse
        conv_done <= 1'b0;
        conv_seq_end <= conv_done;
        // Not valid: keep changing so no stale value is trusted
        conv_chan <= ~conv_chan;
        conv_result <= ~conv_result;
        if (conv_start === 1'b1) begin
            cnt <= int'(lat);
        end else if (cnt == 0) begin
            conv_done <= 1'b1;
            conv_chan <= chan;
            conv_result <= res;
            cnt <= -1;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule // atr_far_model

/* File: verification/atr_ctrl_tb.sv */
// Bench: APB master, trigger sources and result stream for the block.
// Assumes the far-side model and checker files are compiled first.
`timescale 1ns/1ps
module atr_ctrl_tb;
    import atr_pkg::*;
    logic clk = 1'b0; // 10 MHz core clock
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdv;
    logic tm8 = 1'b0, ext_n = 1'b1, fire = 1'b0, errv;
    logic [2:0] f_chan = 3'h0, cchan;
    logic [9:0] f_res = 10'h0, cres;
    logic [7:0] lat = 8'h2; // Far-side latency, raised for busy reads
    logic pready, pslverr, tmr, cdone, cend, cstart;
    logic over, under, idone, irng;
    logic [3:0] sclk;
    int n_errors = 0, checks = 0;
    int n_start = 0, n_end = 0, n_done = 0, n_range = 0;
    always #50 clk = ~clk;
    // Event counters, so one-cycle pulses are never missed
    always @(posedge clk) begin
        n_start <= n_start + (cstart === 1'b1 ? 1 : 0);
        n_end <= n_end + (cend === 1'b1 ? 1 : 0);
        n_done <= n_done + (idone === 1'b1 ? 1 : 0);
        n_range <= n_range + (irng === 1'b1 ? 1 : 0);
    end
    atr_ctrl atr_ctrl_inst (.CORE_CLK(clk), .RST(rst), .CORE_CE(1'b1),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TMR_MATCH(tmr), .TM8_UNDERFLOW(tm8),
        .EXT_TRIG(ext_n), .CONV_DONE(cdone), .CONV_CHAN(cchan),
        .CONV_RESULT(cres), .CONV_SEQ_END(cend), .CONV_START(cstart),
        .SAMPLE_CLKS(sclk), .TMR_OVER(over), .TMR_UNDER(under),
        .IRQ_DONE(idone), .IRQ_RANGE(irng));
    atr_far_model atr_far_model_inst (.clk(clk), .fire(fire), .lat(lat),
        .chan(f_chan), .res(f_res), .conv_start(cstart), .tmr_match(tmr),
        .conv_done(cdone), .conv_chan(cchan), .conv_result(cres),
        .conv_seq_end(cend));
    task automatic give_verdict();
        if (n_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [15:0] idx,
        input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {14'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            give_verdict();
        end
    endtask
    // Pulse a source (1 timer, 2 eight-bit timer, 3 pin), wait for idle
    task automatic kick(input int src);
        int n;
        @(posedge clk);
        fire <= (src == 1);
        tm8 <= (src == 2);
        ext_n <= (src != 3);
        @(posedge clk);
        fire <= 1'b0;
        tm8 <= 1'b0;
        ext_n <= 1'b1;
        n = 0;
        repeat (6) @(posedge clk);
        while (n_end != n_start && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n == 300) begin
            n_errors++;
            give_verdict();
        end
        repeat (2) @(posedge clk);
    endtask
    task automatic row(input logic [15:0] c, input logic [7:0] m,
        input logic [2:0] ch, input logic [9:0] r, input logic [3:0] e);
        int d0;
        int r0;
        apb(1'b1, MSK_IDX, {24'h0, m});
        apb(1'b1, CTL_IDX, {16'h0, c});
        d0 = n_done;
        r0 = n_range;
        f_chan <= ch;
        f_res <= r;
        kick(1);
        chk("over flag", {31'h0, over}, {31'h0, e[3]});
        chk("under flag", {31'h0, under}, {31'h0, e[2]});
        chk("done irq", 32'(n_done - d0), {31'h0, e[1]});
        chk("range irq", 32'(n_range - r0), {31'h0, e[0]});
    endtask
    task automatic t_reset();
        chk("sample clocks", {28'h0, sclk}, 32'h9);
        apb(1'b0, CTL_IDX, 32'h0);
        chk("control std", rdv, 32'h300);
        apb(1'b1, UPR_IDX, 32'h155);
        apb(1'b0, UPR_IDX, 32'h0);
        chk("upper hidden", rdv, 32'h0);
        apb(1'b0, 16'h5560, 32'h0);
        chk("unmapped error", {31'h0, errv}, 32'h1);
        apb(1'b1, ADV_IDX, 32'h100);
        apb(1'b0, CTL_IDX, 32'h0);
        chk("control adv", rdv, 32'h310);
        apb(1'b0, MSK_IDX, 32'h0);
        chk("mask", rdv, 32'hFF);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, CTL_IDX, 32'(s) << 8);
            repeat (2) @(posedge clk);
            chk("sample clocks", {28'h0, sclk}, 32'(3 + 2 * s));
        end
    endtask
    task automatic t_trig();
        int s0;
        apb(1'b1, TRIG_IDX, 32'(TRG_TMR) << 3);
        s0 = n_start;
        kick(1);
        chk("start while off", 32'(n_start - s0), 32'h0);
        apb(1'b1, CTL_IDX, 32'h304);
        for (int t = 0; t < 4; t++) begin
            apb(1'b1, TRIG_IDX, 32'(t) << 3);
            for (int src = 1; src < 4; src++) begin
                s0 = n_start;
                kick(src);
                chk("start", 32'(n_start - s0), 32'(src == t));
            end
        end
        lat <= 8'd40;
        apb(1'b1, TRIG_IDX, 32'(TRG_SW) << 3);
        s0 = n_start;
        apb(1'b1, CTL_IDX, 32'h306); // Software start
        apb(1'b0, CTL_IDX, 32'h0);
        chk("busy bit", {31'h0, rdv[START_BIT]}, 32'h1);
        chk("sw start", 32'(n_start - s0), 32'h1);
        kick(0);
        apb(1'b0, CTL_IDX, 32'h0);
        chk("idle bit", {31'h0, rdv[START_BIT]}, 32'h0);
        lat <= 8'd2;
    endtask
    task automatic t_range();
        apb(1'b1, TRIG_IDX, 32'(TRG_TMR) << 3);
        apb(1'b1, UPR_IDX, 32'h200);
        apb(1'b1, LWR_IDX, 32'h100);
        apb(1'b0, UPR_IDX, 32'h0);
        chk("upper limit", rdv, 32'h200);
        row(16'h8324, 8'hFF, 3'h0, 10'h201, 4'b1010);
        row(16'h8324, 8'hFF, 3'h0, 10'h200, 4'b0000);
        row(16'h8324, 8'hFF, 3'h0, 10'h0FF, 4'b0110);
        row(16'h8324, 8'hFF, 3'h0, 10'h100, 4'b0000);
        row(16'h8364, 8'hFF, 3'h0, 10'h3FF, 4'b1001);
        row(16'h9364, 8'hFF, 3'h0, 10'h3FF, 4'b1000);
        row(16'h9364, 8'hFF, 3'h1, 10'h000, 4'b1001);
        row(16'hC364, 8'hFF, 3'h4, 10'h3FF, 4'b1000);
        row(16'h0364, 8'hFF, 3'h0, 10'h3FF, 4'b0000);
        row(16'h8344, 8'hFF, 3'h0, 10'h3FF, 4'b1000);
        row(16'h8314, 8'hFF, 3'h0, 10'h150, 4'b0010);
        row(16'h8314, 8'hFE, 3'h0, 10'h150, 4'b0000);
        row(16'h8314, 8'hFE, 3'h1, 10'h150, 4'b0010);
        row(16'h8304, 8'hFF, 3'h0, 10'h150, 4'b0000);
        apb(1'b1, ADV_IDX, 32'h0);
        row(16'h8364, 8'hFF, 3'h0, 10'h3FF, 4'b0010);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_trig();
        t_range();
        give_verdict();
    end
endmodule // atr_ctrl_tb
bind atr_ctrl atr_ctrl_assertions atr_ctrl_assertions_inst (
    .CORE_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .TMR_MATCH, .TM8_UNDERFLOW, .EXT_TRIG, .CONV_DONE, .CONV_CHAN,
    .CONV_START, .SAMPLE_CLKS, .TMR_OVER, .TMR_UNDER, .IRQ_DONE,
    .IRQ_RANGE);
